/* File: hw/smp_pkg.sv */
package smp_pkg;
	localparam int          CLK_HZ      = 40_000_000;
	localparam int          MS_PER_S    = 1000;
	localparam int          UPDATE_MS   = 32;
	localparam int          UPDATE_CYC  = CLK_HZ / MS_PER_S * UPDATE_MS;
	localparam logic [15:0] MIN_TARGET  = 16'h0032;
	localparam int          ECYCLES     = 16;
	localparam int          STEPS_PER_EC = 4;
	localparam logic [6:0]  LEARN_STEPS = 7'(ECYCLES * STEPS_PER_EC);
	localparam logic [2:0]  PAUSE_TICKS = 3'h4;
	// register byte offsets
	localparam logic [7:0]  A_CTRL   = 8'h00;
	localparam logic [7:0]  A_START  = 8'h04;
	localparam logic [7:0]  A_TARGET = 8'h08;
	localparam logic [7:0]  A_STOP   = 8'h0c;
	localparam logic [7:0]  A_ACCEL  = 8'h10;
	localparam logic [7:0]  A_NSTEPS = 8'h14;
	localparam logic [7:0]  A_DECEL  = 8'h18;
	localparam logic [7:0]  A_STATUS = 8'h1c;
	localparam logic [7:0]  A_COUNT  = 8'h20;
	// control and status bit positions
	localparam int C_START = 0;
	localparam int C_STOP  = 1;
	localparam int C_CNT   = 2;
	localparam int C_RECIP = 3;
	localparam int C_LEARN = 4;
	localparam int C_REV   = 5;
	localparam int C_DIR   = 6;
	localparam int S_BUSY  = 0;
	localparam int S_PRMPT = 1;
	localparam int S_LDONE = 2;
	localparam int S_STALL = 3;
	localparam int S_DIR   = 4;
	// reset values
	localparam logic [15:0] RST_START  = 16'h00c8;
	localparam logic [15:0] RST_TARGET = 16'h03e8;
	localparam logic [15:0] RST_STOP   = 16'h00c8;
	localparam logic [15:0] RST_ACCEL  = 16'h00c8;
	localparam logic [31:0] RST_NSTEPS = 32'h0000_00c8;
	localparam logic [31:0] RST_DECEL  = 32'h0000_00c8;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_UP     = 3'b001,
		ST_CRUISE = 3'b010,
		ST_DOWN   = 3'b011,
		ST_PAUSE  = 3'b100
	} smp_mode_e;

	typedef struct packed {
		logic outputsOff;
		logic faultOutN;
		logic learnCompleteFlag;
		logic blockageDetected;
	} smp_drv_in_s;

	typedef struct packed {
		smp_mode_e   st;
		logic [15:0] rate;
		logic [15:0] startRate;
		logic [15:0] targetRate;
		logic [15:0] stopRate;
		logic [15:0] accel;
		logic [31:0] numSteps;
		logic [31:0] decelAt;
		logic [31:0] count;
		logic [31:0] prdata;
		logic [25:0] period;
		logic [25:0] pcnt;
		logic [20:0] tick;
		logic [6:0]  ecnt;
		logic [2:0]  pauseN;
		logic        counted;
		logic        recip;
		logic        learnEn;
		logic        revEn;
		logic        dir;
		logic        stepOut;
		logic        stopReq;
		logic        learnPulse;
		logic        learning;
		logic        prompt;
		logic        learnDone;
		logic        stallSt;
		logic        stallPrev;
	} smp_state_s;
endpackage : smp_pkg

/* File: hw/smp_stepper_gen.sv */
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module smp_stepper_gen #(
	parameter int unsigned TICK_CYCLES = smp_pkg::UPDATE_CYC
) (
	input  wire logic                clk_sys,
	input  wire logic                nrst,
	input  wire logic                ce,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire smp_pkg::smp_drv_in_s drvIn,
	output logic                     stepPulse,
	output logic                     dirOut,
	output logic                     thresholdLearnRequest,
	output logic                     learnPrompt
);
	smp_pkg::smp_state_s q_r;
	smp_pkg::smp_state_s q_nxt;
	logic        running;
	logic        tickHit;
	logic        periodEnd;
	logic        done;
	logic        stallNow;
	logic        stallEdge;
	logic        wrEn;
	logic        startCmd;
	logic        stopCmd;
	logic        startOk;
	logic        mapped;
	logic [20:0] prod;
	logic [20:0] dq;
	logic [15:0] delta;
	logic [16:0] upSum;
	logic [15:0] startEff;
	logic [15:0] tgtEff;
	logic [31:0] rdData;

	// period from rate; a zero rate is treated as one to keep the divide safe
	function automatic logic [25:0] periodOf(input logic [15:0] r);
		logic [31:0] rr;
		rr = {16'h0000, (r == 16'h0000) ? 16'h0001 : r};
		periodOf = 26'(32'(smp_pkg::CLK_HZ) / rr);
	endfunction : periodOf

	// begin a move: first step goes out at once, equal rates skip the ramp
	function automatic smp_pkg::smp_state_s launch(input smp_pkg::smp_state_s s,
		input logic [15:0] sr, input logic [15:0] tr);
		launch = s;
		launch.st = (sr >= tr) ? smp_pkg::ST_CRUISE : smp_pkg::ST_UP;
		launch.rate = (sr >= tr) ? tr : sr;
		launch.period = periodOf(launch.rate);
		launch.pcnt = 26'h0;
		launch.stepOut = 1'b1;
		launch.count = 32'h1;
		launch.tick = 21'h0;
	endfunction : launch

	// decode and derived quantities
	assign running = (q_r.st == smp_pkg::ST_UP) || (q_r.st == smp_pkg::ST_CRUISE)
		|| (q_r.st == smp_pkg::ST_DOWN);
	assign tickHit = (q_r.tick == 21'(TICK_CYCLES - 1));
	assign periodEnd = running && (q_r.pcnt >= q_r.period - 26'h1);
	assign done = periodEnd && q_r.counted && (q_r.count >= q_r.numSteps);
	assign stallNow = !drvIn.faultOutN && drvIn.blockageDetected;
	assign stallEdge = stallNow && !q_r.stallPrev;
	assign wrEn = psel && penable && pwrite;
	assign startCmd = wrEn && (paddr == smp_pkg::A_CTRL) && pwdata[smp_pkg::C_START];
	assign stopCmd = wrEn && (paddr == smp_pkg::A_CTRL) && pwdata[smp_pkg::C_STOP];
	// counted moves of zero steps are meaningless, so such a start is ignored
	assign startOk = startCmd && !drvIn.outputsOff && (q_r.st == smp_pkg::ST_IDLE)
		&& !(pwdata[smp_pkg::C_CNT] && (q_r.numSteps == 32'h0));
	// clamping the target keeps the cruise rate legal even if misprogrammed
	assign tgtEff = (q_r.targetRate < smp_pkg::MIN_TARGET) ? smp_pkg::MIN_TARGET
		: q_r.targetRate;
	assign startEff = (q_r.startRate == 16'h0) ? 16'h1 : q_r.startRate;
	// per-update increment; an increment of zero would stall the ramp forever
	assign prod = 21'(q_r.accel * smp_pkg::UPDATE_MS);
	assign dq = prod / 21'(smp_pkg::MS_PER_S);
	assign delta = (dq == 21'h0) ? 16'h1 : dq[15:0];
	assign upSum = {1'b0, q_r.rate} + {1'b0, delta};

	// read mux, unmapped offsets answer zero with an error
	always_comb begin
		rdData = 32'h0;
		mapped = 1'b1;
		case (paddr)
			smp_pkg::A_CTRL: rdData = {25'h0, q_r.dir, q_r.revEn, q_r.learnEn,
				q_r.recip, q_r.counted, 2'b00};
			smp_pkg::A_START: rdData = {16'h0, q_r.startRate};
			smp_pkg::A_TARGET: rdData = {16'h0, q_r.targetRate};
			smp_pkg::A_STOP: rdData = {16'h0, q_r.stopRate};
			smp_pkg::A_ACCEL: rdData = {16'h0, q_r.accel};
			smp_pkg::A_NSTEPS: rdData = q_r.numSteps;
			smp_pkg::A_DECEL: rdData = q_r.decelAt;
			smp_pkg::A_STATUS: rdData = {q_r.rate, 8'h0, q_r.st, q_r.dir, q_r.stallSt,
				q_r.learnDone, q_r.prompt, q_r.st != smp_pkg::ST_IDLE};
			smp_pkg::A_COUNT: rdData = q_r.count;
			default: mapped = 1'b0;
		endcase
	end

	// next-state logic for the whole block
	always_comb begin
		q_nxt = q_r;
		q_nxt.learnPulse = 1'b0;
		q_nxt.stallPrev = stallNow;
		if (psel && !penable) begin
			q_nxt.prdata = rdData;
		end
		if (wrEn) begin
			case (paddr)
				smp_pkg::A_CTRL: begin
					q_nxt.counted = pwdata[smp_pkg::C_CNT];
					q_nxt.recip = pwdata[smp_pkg::C_RECIP];
					q_nxt.learnEn = pwdata[smp_pkg::C_LEARN];
					q_nxt.revEn = pwdata[smp_pkg::C_REV];
				end
				smp_pkg::A_START: q_nxt.startRate = pwdata[15:0];
				smp_pkg::A_TARGET: q_nxt.targetRate = pwdata[15:0];
				smp_pkg::A_STOP: q_nxt.stopRate = pwdata[15:0];
				smp_pkg::A_ACCEL: q_nxt.accel = pwdata[15:0];
				smp_pkg::A_NSTEPS: q_nxt.numSteps = pwdata;
				smp_pkg::A_DECEL: q_nxt.decelAt = pwdata;
				smp_pkg::A_STATUS: begin
					if (pwdata[smp_pkg::S_STALL]) begin
						q_nxt.stallSt = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// a counted-bit write mid-move is dropped; the recip, learn and reverse bits apply at once
		if (q_r.st != smp_pkg::ST_IDLE) begin
			q_nxt.counted = q_r.counted;
		end
		if (stopCmd && (q_r.st != smp_pkg::ST_IDLE)) begin
			q_nxt.stopReq = 1'b1;
		end
		case (q_r.st)
			smp_pkg::ST_IDLE: begin
				if (startOk) begin
					q_nxt = launch(q_nxt, startEff, tgtEff);
					q_nxt.dir = pwdata[smp_pkg::C_DIR];
					q_nxt.stopReq = 1'b0;
					q_nxt.learnDone = 1'b0;
					q_nxt.learning = 1'b0;
					q_nxt.prompt = 1'b0;
				end
			end
			smp_pkg::ST_UP, smp_pkg::ST_CRUISE, smp_pkg::ST_DOWN: begin
				q_nxt.tick = tickHit ? 21'h0 : q_r.tick + 21'h1;
				if (periodEnd) begin
					q_nxt.pcnt = 26'h0;
				end else begin
					q_nxt.pcnt = q_r.pcnt + 26'h1;
					if (q_r.pcnt == (q_r.period >> 1)) begin
						q_nxt.stepOut = 1'b0;
					end
				end
				if (done) begin
					q_nxt.stepOut = 1'b0;
					if (q_r.recip && !q_nxt.stopReq) begin
						q_nxt = launch(q_nxt, startEff, tgtEff);
						q_nxt.dir = !q_r.dir;
					end else begin
						q_nxt.st = smp_pkg::ST_IDLE;
					end
				end else begin
					if (periodEnd) begin
						// reload only at a boundary so no pulse is cut short
						q_nxt.period = periodOf(q_r.rate);
						q_nxt.stepOut = 1'b1;
						q_nxt.count = q_r.count + 32'h1;
						if (q_r.learning && !q_r.prompt) begin
							q_nxt.ecnt = q_r.ecnt + 7'h1;
							if (q_r.ecnt + 7'h1 == smp_pkg::LEARN_STEPS) begin
								q_nxt.prompt = 1'b1;
							end
						end
						if (q_r.counted && (q_r.count + 32'h1 == q_r.decelAt)
							&& (q_r.st != smp_pkg::ST_DOWN)) begin
							q_nxt.st = smp_pkg::ST_DOWN;
						end
					end
					if (q_nxt.stopReq && !q_r.counted && (q_r.st != smp_pkg::ST_DOWN)) begin
						q_nxt.st = smp_pkg::ST_DOWN;
					end else if (tickHit && (q_r.st == smp_pkg::ST_UP)) begin
						if (upSum >= {1'b0, tgtEff}) begin
							q_nxt.rate = tgtEff;
							// a decel point landing on this tick must not be undone by the clamp
							q_nxt.st = (q_nxt.st == smp_pkg::ST_UP) ? smp_pkg::ST_CRUISE : q_nxt.st;
						end else begin
							q_nxt.rate = upSum[15:0];
						end
					end else if (tickHit && (q_r.st == smp_pkg::ST_DOWN)) begin
						if ({1'b0, q_r.rate} <= {1'b0, q_r.stopRate} + {1'b0, delta}) begin
							q_nxt.rate = q_r.stopRate;
							if (!q_r.counted) begin
								q_nxt.st = smp_pkg::ST_IDLE;
								q_nxt.stepOut = 1'b0;
							end
						end else begin
							q_nxt.rate = q_r.rate - delta;
						end
					end
				end
			end
			smp_pkg::ST_PAUSE: begin
				q_nxt.tick = tickHit ? 21'h0 : q_r.tick + 21'h1;
				if (q_nxt.stopReq) begin
					q_nxt.st = smp_pkg::ST_IDLE;
				end else if (tickHit) begin
					q_nxt.pauseN = q_r.pauseN + 3'h1;
					if (q_r.pauseN == smp_pkg::PAUSE_TICKS - 3'h1) begin
						q_nxt = launch(q_nxt, startEff, tgtEff);
						q_nxt.dir = !q_r.dir;
					end
				end
			end
			default: q_nxt.st = smp_pkg::ST_IDLE;
		endcase
		// a stall that lands on a clear still shows: set wins
		if (stallEdge && running) begin
			q_nxt.stallSt = 1'b1;
			if (q_r.revEn) begin
				q_nxt.st = smp_pkg::ST_PAUSE;
				q_nxt.pauseN = 3'h0;
				q_nxt.tick = 21'h0;
				q_nxt.stepOut = 1'b0;
			end
		end
		if (q_r.prompt && stallNow && drvIn.learnCompleteFlag) begin
			q_nxt.learnDone = 1'b1;
			q_nxt.prompt = 1'b0;
			q_nxt.learning = 1'b0;
		end
		// losing the driver outputs aborts at once
		if (drvIn.outputsOff) begin
			q_nxt.st = smp_pkg::ST_IDLE;
			q_nxt.stepOut = 1'b0;
		end
		// learning is asked for once per start, only in continuous mode
		if ((q_nxt.st == smp_pkg::ST_CRUISE) && (q_r.st != smp_pkg::ST_CRUISE)
			&& !q_nxt.counted && q_r.learnEn && !q_r.learning && !q_nxt.learnDone) begin
			q_nxt.learnPulse = 1'b1;
			q_nxt.learning = 1'b1;
			q_nxt.ecnt = 7'h0;
		end
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q_r <= '0;
			q_r.startRate <= smp_pkg::RST_START;
			q_r.targetRate <= smp_pkg::RST_TARGET;
			q_r.stopRate <= smp_pkg::RST_STOP;
			q_r.accel <= smp_pkg::RST_ACCEL;
			q_r.numSteps <= smp_pkg::RST_NSTEPS;
			q_r.decelAt <= smp_pkg::RST_DECEL;
		end else if (ce) begin
			q_r <= q_nxt;
		end
	end

	// outputs
	assign prdata = q_r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign stepPulse = q_r.stepOut;
	assign dirOut = q_r.dir;
	assign thresholdLearnRequest = q_r.learnPulse;
	assign learnPrompt = q_r.prompt;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	offIdle_a: assert property (ce && drvIn.outputsOff |=> q_r.st == smp_pkg::ST_IDLE)
		else $error("moving while driver outputs off");
	startRate_a: assert property (ce && startOk && (startEff < tgtEff)
		|=> q_r.rate == $past(startEff) && stepPulse && q_r.st == smp_pkg::ST_UP)
		else $error("start not at starting rate");
	rampInc_a: assert property (ce && tickHit && q_r.st == smp_pkg::ST_UP
		&& upSum < {1'b0, tgtEff} && !q_nxt.stopReq && !drvIn.outputsOff && !done
		&& !stallEdge |=> q_r.rate == $past(q_r.rate) + $past(delta))
		else $error("ramp increment wrong");
	rampHold_a: assert property (ce && !tickHit && q_r.st == smp_pkg::ST_UP && !done
		|=> $stable(q_r.rate))
		else $error("rate changed between updates");
	equalSkip_a: assert property (ce && startOk && startEff == tgtEff
		|=> q_r.st == smp_pkg::ST_CRUISE && q_r.rate == $past(tgtEff))
		else $error("equal rates still ramped");
	cruiseFloor_a: assert property (q_r.st == smp_pkg::ST_CRUISE
		|-> q_r.rate >= smp_pkg::MIN_TARGET)
		else $error("cruise below minimum target");
	cruiseHold_a: assert property (ce && q_r.st == smp_pkg::ST_CRUISE && !q_r.counted
		&& !q_nxt.stopReq && !drvIn.outputsOff && !stallEdge
		|=> q_r.st == smp_pkg::ST_CRUISE && $stable(q_r.rate))
		else $error("continuous cruise left without stop");
	countEnd_a: assert property (ce && done && !q_r.recip && !drvIn.outputsOff
		&& !stallEdge |=> q_r.st == smp_pkg::ST_IDLE ##1 !stepPulse)
		else $error("counted move overran");
	decelAt_a: assert property (ce && periodEnd && !done && q_r.counted
		&& q_r.count + 32'h1 == q_r.decelAt && !drvIn.outputsOff && !stallEdge
		|=> q_r.st == smp_pkg::ST_DOWN)
		else $error("ramp down missed decel point");
	learnReq_a: assert property (thresholdLearnRequest
		|-> q_r.st == smp_pkg::ST_CRUISE && !q_r.counted)
		else $error("learn request outside continuous cruise");
	prompt_a: assert property ($rose(learnPrompt) |-> q_r.ecnt == smp_pkg::LEARN_STEPS)
		else $error("stall prompt at wrong cycle count");
	learned_a: assert property (ce && q_r.prompt && stallNow && drvIn.learnCompleteFlag
		|=> q_r.learnDone && !learnPrompt)
		else $error("learning completion missed");
	reverse_a: assert property (ce && q_r.st == smp_pkg::ST_PAUSE && tickHit
		&& q_r.pauseN == smp_pkg::PAUSE_TICKS - 3'h1 && !q_nxt.stopReq
		&& !drvIn.outputsOff |=> dirOut != $past(dirOut) && stepPulse)
		else $error("no reversal after stall pause");

	cruise_c: cover property (q_r.st == smp_pkg::ST_UP ##1 q_r.st == smp_pkg::ST_CRUISE);
	recip_c: cover property (ce && done && q_r.recip ##1 q_r.st != smp_pkg::ST_IDLE);
	learn_c: cover property ($rose(q_r.learnDone));
	pause_c: cover property (q_r.st == smp_pkg::ST_PAUSE ##1 running);
endmodule : smp_stepper_gen

/* File: testbench/smp_drv_model.sv */
`timescale 1ns/1ps
// behavioural stepper driver: reports stalls and finishes threshold learning
module smp_drv_model (
	input  wire logic            clk_sys,
	input  wire logic            nrst,
	input  wire logic            stepPulse,
	input  wire logic            thresholdLearnRequest,
	input  wire logic            outputsOff,
	input  wire logic            stallCmd,
	input  wire logic            clrFault,
	output smp_pkg::smp_drv_in_s drvIn
);
	localparam int RUN_TORQUE  = 100;
	localparam int HELD_TORQUE = 20;
	localparam int BLOCK_TH    = 60;
	int   torqueMeasure;
	logic learning;
	logic faulted;

	// a held rotor drags the torque reading under the threshold; keeping the threshold
	// below the running torque means a free rotor never reports a false stall
	assign torqueMeasure = stallCmd ? HELD_TORQUE : RUN_TORQUE;

	// a blocked rotor only shows while being stepped; the fault stays until cleared rotor-free
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			learning <= 1'b0;
			faulted  <= 1'b0;
		end else begin
			if (thresholdLearnRequest)
				learning <= 1'b1;
			if ((torqueMeasure < BLOCK_TH) && stepPulse)
				faulted <= 1'b1;
			else if (clrFault && !stallCmd)
				faulted <= 1'b0;
		end
	end

	// status pins seen by the generator
	// one driver for the whole struct: off, fault (low active), learned, blocked
	assign drvIn = {outputsOff, ~faulted, faulted & learning, faulted};
endmodule : smp_drv_model

/* File: testbench/smp_stepper_gen_tb.sv */
`timescale 1ns/1ps
module smp_stepper_gen_tb;
	localparam int          TICK  = 1000;
	localparam logic [31:0] M_GO  = 32'h1 << smp_pkg::C_START;
	localparam logic [31:0] M_STP = 32'h1 << smp_pkg::C_STOP;
	localparam logic [31:0] M_CNT = 32'h1 << smp_pkg::C_CNT;
	localparam logic [31:0] M_REC = 32'h1 << smp_pkg::C_RECIP;
	localparam logic [31:0] M_LRV = (32'h1 << smp_pkg::C_LEARN) | (32'h1 << smp_pkg::C_REV);
	localparam logic [31:0] M_DIR = 32'h1 << smp_pkg::C_DIR;
	logic                 clk_sys = 1'b0;
	logic                 nrst    = 1'b0;
	logic                 ce      = 1'b1;
	logic                 psel    = 1'b0;
	logic                 penable = 1'b0;
	logic                 pwrite  = 1'b0;
	logic [7:0]           paddr   = 8'h00;
	logic [31:0]          pwdata  = 32'h0;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	smp_pkg::smp_drv_in_s drvIn;
	logic                 stepPulse;
	logic                 dirOut;
	logic                 thresholdLearnRequest;
	logic                 learnPrompt;
	logic                 outputsOff = 1'b0;
	logic                 stallCmd   = 1'b0;
	logic                 clrFault   = 1'b0;
	logic                 stepPrev   = 1'b0;
	logic [31:0]          rd;
	logic                 er;
	int n_mismatch = 0;
	int tests_run  = 0;
	int nEdge      = 0;
	int nReq       = 0;
	int edgeAtReq  = 0;
	int cyc        = 0;

	always #12.5 clk_sys = ~clk_sys;

	// step edges and learn requests, counted as the driver would see them
	always @(posedge clk_sys) begin
		cyc      <= cyc + 1;
		stepPrev <= stepPulse;
		if (stepPulse === 1'b1 && stepPrev !== 1'b1)
			nEdge <= nEdge + 1;
		if (thresholdLearnRequest === 1'b1) begin
			nReq      <= nReq + 1;
			edgeAtReq <= nEdge;
		end
	end

	smp_stepper_gen #(.TICK_CYCLES(TICK)) u_smp_stepper_gen (
		.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .drvIn(drvIn), .stepPulse(stepPulse),
		.dirOut(dirOut), .thresholdLearnRequest(thresholdLearnRequest),
		.learnPrompt(learnPrompt));

	smp_drv_model u_smp_drv_model (
		.clk_sys(clk_sys), .nrst(nrst), .stepPulse(stepPulse),
		.thresholdLearnRequest(thresholdLearnRequest), .outputsOff(outputsOff),
		.stallCmd(stallCmd), .clrFault(clrFault), .drvIn(drvIn));

	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	task fail(input string m);
		n_mismatch++;
		$display("[FAIL] %0t %s", $time, m);
		tally_and_finish();
	endtask : fail

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	// one apb transfer; pready is sampled, never assumed
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1)
			fail("apb hang");
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdr(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rdr

	task cfg(input logic [15:0] s, input logic [15:0] t, input logic [15:0] p);
		wr(smp_pkg::A_START, {16'h0, s});
		wr(smp_pkg::A_TARGET, {16'h0, t});
		wr(smp_pkg::A_STOP, {16'h0, p});
		wr(smp_pkg::A_ACCEL, 32'h0000_ffff);
	endtask : cfg

	task waitSt(input logic [2:0] s);
		for (int i = 0; i < 4000; i++) begin
			rdr(smp_pkg::A_STATUS);
			if (rd[7:5] === s)
				return;
		end
		fail("state wait");
	endtask : waitSt

	task waitEdges(input int n);
		int t;
		t = nEdge + n;
		for (int i = 0; i < n * 2000; i++) begin
			if (nEdge >= t)
				return;
			@(posedge clk_sys);
		end
		fail("step wait");
	endtask : waitEdges

	task automatic waitSig(ref logic s, input logic v, input int n);
		for (int i = 0; i < n; i++) begin
			if (s === v)
				return;
			@(posedge clk_sys);
		end
		fail("signal wait");
	endtask : waitSig

	task s_regs;
		for (int k = 0; k < 6; k++) begin
			rdr(8'h04 + 8'(4 * k));
			chk(rd, (k == 1) ? 32'h0000_03e8 : 32'h0000_00c8, "cfg reset");
		end
		rdr(8'h24);
		chk({31'h0, er}, 32'h1, "unmapped err");
		chk(rd, 32'h0, "unmapped data");
	endtask : s_regs

	// start with driver outputs off must be ignored
	task s_off;
		int e;
		e = nEdge;
		outputsOff <= 1'b1;
		wr(smp_pkg::A_CTRL, M_GO);
		repeat (20) @(posedge clk_sys);
		rdr(smp_pkg::A_STATUS);
		chk({31'h0, rd[0]}, 32'h0, "busy when off");
		chk(32'(nEdge - e), 32'h0, "steps when off");
		outputsOff <= 1'b0;
	endtask : s_off

	// equal start and target: no ramp, period is clock over rate
	task s_equal;
		int t0;
		cfg(16'd40000, 16'd40000, 16'd40000);
		wr(smp_pkg::A_CTRL, M_DIR | M_GO);
		chk({31'h0, dirOut}, 32'h1, "dir bit");
		rdr(smp_pkg::A_STATUS);
		chk({29'h0, rd[7:5]}, 32'h2, "no ramp");
		chk({16'h0, rd[31:16]}, 32'd40000, "start rate");
		waitEdges(1);
		t0 = cyc;
		waitEdges(1);
		chk(32'(cyc - t0), 32'd1000, "step period");
		wr(smp_pkg::A_CTRL, M_STP);
		waitSt(3'h0);
	endtask : s_equal

	// continuous ramp up, hold, stop ramp down
	task s_ramp;
		int e;
		cfg(16'd40000, 16'd50000, 16'd40000);
		wr(smp_pkg::A_CTRL, M_GO);
		rdr(smp_pkg::A_STATUS);
		chk({16'h0, rd[31:16]}, 32'd40000, "ramp start");
		for (int i = 0; i < 2000 && rd[31:16] === 16'd40000; i++)
			rdr(smp_pkg::A_STATUS);
		chk({16'h0, rd[31:16]}, 32'd40000 + 32'd65535 * 32 / 1000, "ramp step");
		waitSt(3'h2);
		chk({16'h0, rd[31:16]}, 32'd50000, "target");
		repeat (3 * TICK) @(posedge clk_sys);
		rdr(smp_pkg::A_STATUS);
		chk({29'h0, rd[7:5]}, 32'h2, "cruise held");
		wr(smp_pkg::A_CTRL, M_STP);
		rdr(smp_pkg::A_STATUS);
		chk({29'h0, rd[7:5]}, 32'h3, "stop ramps");
		waitSt(3'h0);
		e = nEdge;
		repeat (2000) @(posedge clk_sys);
		chk(32'(nEdge - e), 32'h0, "halted");
	endtask : s_ramp

	// counted moves: abrupt end, then decel point and stop-rate tail
	task s_count;
		int e;
		cfg(16'd60000, 16'd60000, 16'd50000);
		wr(smp_pkg::A_NSTEPS, 32'd5);
		wr(smp_pkg::A_DECEL, 32'd100);
		e = nEdge;
		wr(smp_pkg::A_CTRL, M_CNT | M_GO);
		waitSt(3'h0);
		repeat (700) @(posedge clk_sys);
		chk(32'(nEdge - e), 32'd5, "abrupt count");
		rdr(smp_pkg::A_COUNT);
		chk(rd, 32'd5, "count reg");
		wr(smp_pkg::A_NSTEPS, 32'd20);
		wr(smp_pkg::A_DECEL, 32'd2);
		e = nEdge;
		wr(smp_pkg::A_CTRL, M_CNT | M_GO);
		waitEdges(3);
		rdr(smp_pkg::A_STATUS);
		chk({29'h0, rd[7:5]}, 32'h3, "decel point");
		waitEdges(12);
		rdr(smp_pkg::A_STATUS);
		chk({16'h0, rd[31:16]}, 32'd50000, "stop rate tail");
		waitSt(3'h0);
		repeat (700) @(posedge clk_sys);
		chk(32'(nEdge - e), 32'd20, "tail count");
	endtask : s_count

	// reciprocation flips direction per move until stopped
	task s_recip;
		int   e;
		logic d0;
		wr(smp_pkg::A_NSTEPS, 32'd3);
		wr(smp_pkg::A_DECEL, 32'd100);
		d0 = dirOut;
		e  = nEdge;
		wr(smp_pkg::A_CTRL, M_CNT | M_REC | M_GO);
		waitSig(dirOut, ~d0, 20000);
		wr(smp_pkg::A_CTRL, M_CNT | M_REC | M_STP);
		waitSt(3'h0);
		repeat (700) @(posedge clk_sys);
		chk(32'((nEdge - e) % 3), 32'h0, "whole moves");
		chk({31'h0, (nEdge - e) >= 6}, 32'h1, "repeated");
	endtask : s_recip

	// learning handshake, then stall with reverse enabled
	task s_learn;
		int   r;
		logic d0;
		cfg(16'd55000, 16'd60000, 16'd40000);
		r = nReq;
		wr(smp_pkg::A_CTRL, M_LRV | M_GO);
		waitSig(learnPrompt, 1'b1, 60000);
		chk(32'(nReq - r), 32'h1, "learn request");
		chk({31'h0, (nEdge - edgeAtReq) inside {[63:65]}}, 32'h1, "learn steps");
		d0 = dirOut;
		stallCmd <= 1'b1;
		waitSig(learnPrompt, 1'b0, 2000);
		rdr(smp_pkg::A_STATUS);
		chk({30'h0, rd[3:2]}, 32'h3, "learned stall");
		chk({29'h0, rd[7:5]}, 32'h4, "pause");
		stallCmd <= 1'b0;
		waitSt(3'h1);
		chk({31'h0, dirOut}, {31'h0, ~d0}, "reversed");
		clrFault <= 1'b1;
		@(posedge clk_sys);
		clrFault <= 1'b0;
		wr(smp_pkg::A_CTRL, M_STP);
		waitSt(3'h0);
		wr(smp_pkg::A_STATUS, 32'h1 << smp_pkg::S_STALL);
		rdr(smp_pkg::A_STATUS);
		chk({31'h0, rd[3]}, 32'h0, "stall sticky cleared");
	endtask : s_learn

	// main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		s_regs();
		s_off();
		s_equal();
		s_ramp();
		s_count();
		s_recip();
		s_learn();
		tally_and_finish();
	end
endmodule : smp_stepper_gen_tb
